// >>> hw/frame_fifo.sv
`timescale 1ns/10ps
module frame_fifo #(
    parameter int DATA_W = 16,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [DATA_W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [DATA_W-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("frame_fifo depth must be a power of two of at least 2");
        end
    end

    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = i_valid && !full;
    wire pop = o_valid && i_ready;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : frame_fifo

// >>> hw/sipo_expander.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R01] Clear low forces every latch and parallel output to zero.
// [R02] Clear never touches the shift register.
// [R03] Shift register and latch are both sixteen bits.
// [R04] Each rising shift clock edge shifts serial data in one stage.
// [R05] Strobe high holds the latches while shifting continues.
// [R06] Strobe falling copies the shift register into the latches.
// [R07] Shifting never depends on the strobe.
// [R08] Strobe low with clear high makes latches follow the shift register.
// [R09] Host stops shift clock during strobe low unless outputs should ripple.
// [R10] Cascade output always shows the last shift stage.
// [R11] Cascade output feeds the next device's serial data input.
// [R12] Host keeps shift clock and data within the maximum rate.
// [R13] First bit of a frame lands on the highest output and cascade stage.
// [R14] Host raises strobe, shifts, stops clock, then pulses strobe low.
module sipo_expander
    import sipo_expander_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_serial_data,
    input wire logic i_shift_clk,
    input wire logic i_latch_strobe,
    input wire logic i_clear_n,
    output logic [WIDTH-1:0] o_parallel_out,
    output logic o_cascade_out,
    output logic [WIDTH-1:0] o_frame_data,
    output logic o_frame_valid,
    input wire logic i_frame_ready,
    output logic o_frame_dropped
);
    initial begin
        if (WIDTH != 16) begin
            $error("sipo_expander is built for a sixteen bit register");
        end
    end

    logic shift_clk_q;
    logic [WIDTH-1:0] shift_q;
    logic [WIDTH-1:0] latch_q;
    logic strobe_q;
    logic dropped_q;
    logic fifo_ready;

    // Shift clock is sampled synchronously; a rising edge is one system cycle pulse.
    wire shift_rise = i_shift_clk && !shift_clk_q;
    // Newest bit enters stage 0, so the earliest bit ends at the top stage. [R13]
    wire [WIDTH-1:0] shift_d = {shift_q[WIDTH-2:0], i_serial_data};
    wire strobe_fall = strobe_q && !i_latch_strobe;
    wire transparent = !i_latch_strobe && i_clear_n;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_clk_q <= 1'b0;
            strobe_q <= 1'b1;
        end else begin
            shift_clk_q <= i_shift_clk;
            strobe_q <= i_latch_strobe;
        end
    end

    // Clear is not looked at here, so the shift contents survive it. [R02]
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_q <= SHIFT_RESET;
        end else if (shift_rise) begin
            shift_q <= shift_d; // [R04] [R07] [R03]
        end
    end

    // The latch clears while clear is low, follows the register while transparent and holds otherwise.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_q <= LATCH_RESET;
        end else if (!i_clear_n) begin
            latch_q <= LATCH_RESET; // [R01]
        end else if (transparent) begin
            latch_q <= shift_rise ? shift_d : shift_q; // [R06] [R08]
        end
        // Strobe high: hold. [R05]
    end

    // Parallel outputs are forced low combinationally as soon as clear goes low.
    assign o_parallel_out = i_clear_n ? latch_q : '0; // [R01]
    assign o_cascade_out = shift_q[WIDTH-1]; // [R10] [R11]

    // Each strobe fall with clear high pushes the transferred frame, or flags it dropped if the FIFO is full.
    wire frame_push = strobe_fall && i_clear_n;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dropped_q <= 1'b0;
        end else begin
            dropped_q <= frame_push && !fifo_ready;
        end
    end
    assign o_frame_dropped = dropped_q;

    frame_fifo #(
        .DATA_W(WIDTH),
        .DEPTH(FIFO_DEPTH_P)
    ) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_valid(frame_push),
        .o_ready(fifo_ready),
        .i_data(shift_q),
        .o_valid(o_frame_valid),
        .i_ready(i_frame_ready),
        .o_data(o_frame_data)
    );
endmodule : sipo_expander

// >>> hw/sipo_expander_pkg.sv
package sipo_expander_pkg;

    localparam int WIDTH = 16;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam int FIFO_DEPTH = 32;

    localparam int SYS_CLK_MHZ = 100;
    localparam int SHIFT_MAX_MHZ = 5;
    // Shortest legal shift clock period in system cycles (100 / 5).
    localparam int SHIFT_MIN_CYCLES = SYS_CLK_MHZ / SHIFT_MAX_MHZ;

endpackage : sipo_expander_pkg

// >>> verification/host_model.sv
`timescale 1ns/10ps
module host_model (
    input logic i_clk,
    output logic o_sd = 0, o_sc = 0, o_st = 1, o_cl = 1
);
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task set(input logic s, input logic c);
        o_st = s;
        o_cl = c;
        tick(2);
    endtask : set
    // Twenty cycles a bit is the fastest legal shift rate.
    task send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            o_sd = w[i];
            tick(10);
            o_sc = 1;
            tick(10);
            o_sc = 0;
        end
    endtask : send
    task pulse;
        set(0, 1);
        set(1, 1);
    endtask : pulse
endmodule : host_model

// >>> verification/sipo_expander_properties.sv
`timescale 1ns/10ps
module sipo_expander_properties (
    input logic i_clk, i_resetn, i_shift_clk, i_latch_strobe, i_clear_n, i_frame_ready,
    input logic [15:0] o_parallel_out,
    input logic o_cascade_out, o_frame_valid, o_frame_dropped
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_clear_low: assert property (!i_clear_n |-> !o_parallel_out) else $error("clear");
    a_clear_latch: assert property (!i_clear_n ##1 i_clear_n |-> !o_parallel_out) else $error("clear");
    a_shift_only: assert property (!$rose(i_shift_clk) |=> $stable(o_cascade_out)) else $error("shift");
    a_latch_hold: assert property ($past(i_latch_strobe) && $past(i_clear_n) && i_clear_n
        |-> $stable(o_parallel_out)) else $error("hold");
    a_follow_shift: assert property (!i_latch_strobe && i_clear_n ##1 i_clear_n
        |-> o_parallel_out[15] == o_cascade_out) else $error("follow");
    a_frame_push: assert property ($fell(i_latch_strobe) && i_clear_n && !o_frame_valid
        |=> o_frame_valid) else $error("push");
    a_drop_pulse: assert property (o_frame_dropped |=> !o_frame_dropped) else $error("drop");
    a_valid_hold: assert property (o_frame_valid && !i_frame_ready |=> o_frame_valid) else $error("pop");
    c_drop: cover property (o_frame_dropped);
    c_follow: cover property (!i_latch_strobe && $rose(i_shift_clk));
    c_clear: cover property ($fell(i_clear_n));
endmodule : sipo_expander_properties
bind sipo_expander sipo_expander_properties p (.*);

// >>> verification/sipo_expander_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; $display("FAIL %0t value mismatch", $time); end end
module sipo_expander_tb;
    logic i_clk = 0, i_resetn = 0, i_frame_ready, i_serial_data, i_shift_clk, i_latch_strobe, i_clear_n;
    logic o_cascade_out, o_frame_valid, o_frame_dropped;
    logic [15:0] o_parallel_out, o_frame_data;
    int n_errors = 0, cmp_count = 0, drops = 0, k;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) drops += o_frame_dropped;
    host_model h (.i_clk, .o_sd(i_serial_data), .o_sc(i_shift_clk), .o_st(i_latch_strobe), .o_cl(i_clear_n));
    sipo_expander #(.FIFO_DEPTH_P(4)) dut (.*);
    task end_of_test;
        $display("errors %0d of %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task t_fifo;
        repeat (5) h.pulse();
        i_frame_ready = 1;
        for (k = 0; k < 9 && o_frame_valid; k++) h.tick(1);
        `CHK(k, 4)
        `CHK(drops, 1)
        if (k == 9) end_of_test();
    endtask : t_fifo
    task t_frame;
        h.send(16'ha5c3);
        i_frame_ready = 0;
        h.pulse();
        `CHK(o_frame_data, 16'ha5c3)
        i_frame_ready = 1;
        `CHK(o_parallel_out, 16'ha5c3)
        `CHK(o_cascade_out, 1'h1)
        h.send(16'h1234);
        `CHK(o_parallel_out, 16'ha5c3)
        h.set(1, 0);
        `CHK(o_parallel_out, 16'h0)
        h.pulse();
        `CHK(o_parallel_out, 16'h1234)
    endtask : t_frame
    task t_ripple;
        h.set(0, 1);
        h.send(16'h5a0f);
        `CHK(o_parallel_out, 16'h5a0f)
    endtask : t_ripple
    initial begin
        i_frame_ready = 0;
        h.tick(4);
        i_resetn = 1;
        t_fifo();
        t_frame();
        t_ripple();
        end_of_test();
    end
endmodule : sipo_expander_tb
